// ==== verilog/smpg_top.sv ====
/*
  Stepper move profile generator: APB register file, profile calculation,
  speed ramp, step event generation and the motor and encoder counters.
  Assumes a single 100 MHz clock, synchronous inputs and an APB3 master.
*/
// Our own choices: the register offsets and the APB register port.
// Behaviour
// - Whole profile is computed before motion starts or an error is flagged.
// - Acceleration and deceleration are taken in steps/s per millisecond.
// - Multi-word format saturates position at -32,768,000 and +32,767,999.
// - Double integer format holds the full signed 32-bit position.
// - Preset command loads the supplied value into the position counter.
// - Home found clears motor and encoder counters to zero.
// - Clockwise motion increments position; positive offsets drive clockwise.
// - Base speed accepts only 1 to 1,999,999 steps/s; moves start and end there.
// - Relative target is a signed offset within +/-8,388,607 counts.
// - Absolute target within +/-8,388,607; direction from target versus position.
// - Position passes +/-8,388,607 only by relative moves, never by absolute.
// - Absolute moves are refused until a preset or home has been done.
// - Every move and homing command carries a jerk setting; homing here runs at base speed without a ramp and ignores it.
// - Jerk zero gives a constant rate of speed change.
// - Jerk one gives a slowly ramped S-curve, gentlest at both ends; the rate here grows from 1 at the start of each ramp only.
// - Jerk 2 to 5000 gives S-curve whose constant part grows with jerk.
// - Motion jumps to base speed, then accelerates to cruise speed.
// - Cruise, then decelerate at its own rate to base speed at target.
// - Short ramps against move length give a profile that holds cruise.
// - Long ramps give a peak below cruise, reaching base at target.
`timescale 1ns/1ps
`include "smpg_cfg.svh"

module smpg_top
  import smpg_pkg::*;
#(
  parameter int MS_TICK_CYCLES = `SMPG_MS_CYCLES
)(
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        HOME_IN,
  input  wire logic        ENC_UP,
  input  wire logic        ENC_DN,
  output logic             STEP_PULSE,
  output logic             DIR_CW,
  output logic             MOVING
);

  smpg_state_e        state_r;
  smpg_phase_e        phase_r;
  smpg_cmd_s          cmd_r;
  smpg_stat_s         stat_c;
  logic [2:0]         op_r;
  logic [20:0]        base_r;
  logic               cfg_fmt_r;
  logic signed [31:0] pos_r;
  logic signed [31:0] enc_r;
  logic               valid_r;
  logic               err_r;
  logic               err_pend_r;
  logic               cw_r;
  logic               tri_r;
  logic [33:0]        rem_r;
  logic [20:0]        v_r;
  logic [20:0]        vb_r;
  logic [20:0]        vcr_r;
  logic [20:0]        va_r;
  logic [20:0]        vd_r;
  logic [20:0]        ra_r;
  logic [20:0]        rd_r;
  logic [47:0]        sa_r;
  logic [47:0]        sd_r;
  logic [47:0]        nmil_r;
  logic [26:0]        acc_r;
  logic [16:0]        ms_cnt_r;
  logic               ms_tick_r;

  logic               acc_phase;
  logic               wr_en;
  logic               cmd_go;
  logic               mapped_c;
  logic [31:0]        rdata_c;
  logic signed [33:0] off_c;
  logic [33:0]        n_c;
  logic               bad_c;
  logic [20:0]        cand_a;
  logic [20:0]        cand_d;
  logic               a_ok;
  logic               d_ok;
  logic [27:0]        acc_sum;
  logic               step_c;
  logic               home_hit;
  logic [47:0]        rem_mil;

  function automatic logic [20:0] rate_first(input logic [20:0] rate, input logic [12:0] jerk);
    if (jerk == 13'h0000 || {8'h00, jerk} >= rate)
      return rate;
    return {8'h00, jerk};
  endfunction

  function automatic logic [20:0] rate_next(input logic [20:0] r, input logic [20:0] rate,
                                             input logic [12:0] jerk);
    logic [21:0] s;
    s = {1'b0, r} + {9'h000, jerk};
    if (jerk == 13'h0000 || s >= {1'b0, rate})
      return rate;
    return s[20:0];
  endfunction

  function automatic logic [20:0] add_cap(input logic [20:0] v, input logic [20:0] d,
                                           input logic [20:0] cap);
    logic [21:0] s;
    s = {1'b0, v} + {1'b0, d};
    if (s >= {1'b0, cap})
      return cap;
    return s[20:0];
  endfunction

  // APB: the access phase lasts two cycles; PREADY is a registered pulse.
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end
    else
    begin
      PREADY  <= PSEL & PENABLE & ~PREADY;
      PSLVERR <= PSEL & PENABLE & ~PREADY & ~mapped_c;
      if (PSEL & PENABLE & ~PREADY & ~PWRITE)
        PRDATA <= rdata_c;
    end
  end

  assign wr_en  = PSEL & PENABLE & PWRITE & PREADY;
  assign cmd_go = wr_en && PADDR == `SMPG_ADDR_CMD && state_r == ST_IDLE;

  assign stat_c = '{phase: phase_r, tri_prof: tri_r, cw: cw_r, valid: valid_r,
                    err: err_r, busy: state_r != ST_IDLE};

  always_comb
  begin
    mapped_c = 1'b1;
    rdata_c  = 32'h0000_0000;
    unique case (PADDR)
      `SMPG_ADDR_CMD:    rdata_c = {29'h0000_0000, op_r};
      `SMPG_ADDR_TARGET: rdata_c = cmd_r.target;
      `SMPG_ADDR_SPEED:  rdata_c = {11'h000, cmd_r.speed};
      `SMPG_ADDR_ACCEL:  rdata_c = {11'h000, cmd_r.accel};
      `SMPG_ADDR_DECEL:  rdata_c = {11'h000, cmd_r.decel};
      `SMPG_ADDR_JERK:   rdata_c = {19'h0_0000, cmd_r.jerk};
      `SMPG_ADDR_BASE:   rdata_c = {11'h000, base_r};
      `SMPG_ADDR_CFG:    rdata_c = {31'h0000_0000, cfg_fmt_r};
      `SMPG_ADDR_STATUS: rdata_c = {25'h000_0000, stat_c};
      `SMPG_ADDR_POS:    rdata_c = pos_r;
      `SMPG_ADDR_ENC:    rdata_c = enc_r;
      `SMPG_ADDR_VNOW:   rdata_c = {11'h000, v_r};
      default:           mapped_c = 1'b0;
    endcase
  end

  // Move parameters; the jerk setting rides with every relative and absolute move.
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      cmd_r     <= '0;
      op_r      <= 3'h0;
      cfg_fmt_r <= 1'b0;
      base_r    <= `SMPG_BASE_RST;
    end
    else if (wr_en)
    begin
      unique case (PADDR)
        `SMPG_ADDR_TARGET: cmd_r.target <= PWDATA;
        `SMPG_ADDR_SPEED:  cmd_r.speed  <= PWDATA[20:0];
        `SMPG_ADDR_ACCEL:  cmd_r.accel  <= PWDATA[20:0];
        `SMPG_ADDR_DECEL:  cmd_r.decel  <= PWDATA[20:0];
        `SMPG_ADDR_JERK:   cmd_r.jerk   <= PWDATA[12:0];
        `SMPG_ADDR_CFG:    cfg_fmt_r    <= PWDATA[`SMPG_CFG_FMT_BIT];
        `SMPG_ADDR_BASE:
          if (PWDATA[31:21] == 11'h000 && PWDATA[20:0] >= `SMPG_BASE_MIN && PWDATA[20:0] <= `SMPG_BASE_MAX)
            base_r <= PWDATA[20:0];
        `SMPG_ADDR_CMD:
          if (state_r == ST_IDLE)
            op_r <= PWDATA[2:0];
        default: ;
      endcase
    end
  end

  // Offset and length of the requested move.
  always_comb
  begin
    if (PWDATA[2:0] == `SMPG_OP_ABS)
      off_c = {{2{cmd_r.target[31]}}, cmd_r.target} - {{2{pos_r[31]}}, pos_r};
    else
      off_c = {{2{cmd_r.target[31]}}, cmd_r.target};
    n_c   = off_c[33] ? 34'(-off_c) : off_c;
    bad_c = cmd_r.target > `SMPG_REL_MAX || cmd_r.target < `SMPG_REL_MIN;
    if (PWDATA[2:0] == `SMPG_OP_ABS && !valid_r)
      bad_c = 1'b1;
  end

  // Profile search: both ramps grow from base speed until they meet or hit cruise.
  assign cand_a = add_cap(va_r, ra_r, vcr_r);
  assign cand_d = add_cap(vd_r, rd_r, vcr_r);
  assign a_ok   = va_r < vcr_r && cand_a > va_r && sa_r + sd_r + {27'h0, cand_a} <= nmil_r;
  assign d_ok   = vd_r < vcr_r && cand_d > vd_r && sa_r + sd_r + {27'h0, cand_d} <= nmil_r;

  assign acc_sum  = {1'b0, acc_r} + {7'h00, v_r};
  assign acc_phase = state_r == ST_RUN || state_r == ST_HOME;
  assign step_c   = acc_phase && acc_sum >= `SMPG_STEP_WRAP;
  assign home_hit = state_r == ST_HOME && HOME_IN;
  assign rem_mil  = {14'h0000, rem_r} * `SMPG_ACC_UNIT;

  // One millisecond time base for the speed ramp.
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N || state_r != ST_RUN)
    begin
      ms_cnt_r  <= 17'h0_0000;
      ms_tick_r <= 1'b0;
    end
    else
    begin
      ms_tick_r <= ms_cnt_r == 17'(MS_TICK_CYCLES - 1);
      ms_cnt_r  <= (ms_cnt_r == 17'(MS_TICK_CYCLES - 1)) ? 17'h0_0000 : ms_cnt_r + 17'h0_0001;
    end
  end

  // Move sequencer: calculation, ramp and step pacing.
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      state_r    <= ST_IDLE;
      phase_r    <= PH_ACC;
      err_pend_r <= 1'b0;
      cw_r       <= 1'b0;
      tri_r      <= 1'b0;
      rem_r      <= 34'h0_0000_0000;
      v_r        <= 21'h00_0000;
      vb_r       <= `SMPG_BASE_RST;
      vcr_r      <= `SMPG_BASE_RST;
      va_r       <= `SMPG_BASE_RST;
      vd_r       <= `SMPG_BASE_RST;
      ra_r       <= 21'h00_0000;
      rd_r       <= 21'h00_0000;
      sa_r       <= 48'h0;
      sd_r       <= 48'h0;
      nmil_r     <= 48'h0;
      acc_r      <= 27'h000_0000;
    end
    else
    begin
      acc_r <= step_c ? 27'(acc_sum - `SMPG_STEP_WRAP) : acc_sum[26:0];
      unique case (state_r)
        ST_IDLE:
        begin
          acc_r <= 27'h000_0000;
          v_r   <= 21'h00_0000;
          if (cmd_go && (PWDATA[2:0] == `SMPG_OP_REL || PWDATA[2:0] == `SMPG_OP_ABS))
          begin
            state_r    <= ST_CALC;
            err_pend_r <= bad_c;
            cw_r       <= ~off_c[33] && off_c != 34'sh0;
            rem_r      <= n_c;
            nmil_r     <= {14'h0000, n_c} * `SMPG_ACC_UNIT;
            vb_r       <= base_r;
            vcr_r      <= (cmd_r.speed > base_r) ? cmd_r.speed : base_r;
            va_r       <= base_r;
            vd_r       <= base_r;
            ra_r       <= rate_first(cmd_r.accel, cmd_r.jerk);
            rd_r       <= rate_first(cmd_r.decel, cmd_r.jerk);
            sa_r       <= 48'h0;
            sd_r       <= 48'h0;
          end
          else if (cmd_go && (PWDATA[2:0] == `SMPG_OP_HOME_CW || PWDATA[2:0] == `SMPG_OP_HOME_CCW))
          begin
            state_r <= ST_HOME;
            cw_r    <= PWDATA[2:0] == `SMPG_OP_HOME_CW;
            vb_r    <= base_r;
            v_r     <= base_r;
          end
        end
        ST_CALC:
        begin
          if (a_ok && (va_r <= vd_r || !d_ok))
          begin
            va_r <= cand_a;
            sa_r <= sa_r + {27'h0, cand_a};
            ra_r <= rate_next(ra_r, cmd_r.accel, cmd_r.jerk);
          end
          else if (d_ok)
          begin
            vd_r <= cand_d;
            sd_r <= sd_r + {27'h0, cand_d};
            rd_r <= rate_next(rd_r, cmd_r.decel, cmd_r.jerk);
          end
          else if (err_pend_r || rem_r == 34'h0_0000_0000)
            state_r <= ST_IDLE;
          else
          begin
            state_r <= ST_RUN;
            phase_r <= PH_ACC;
            tri_r   <= va_r < vcr_r;
            v_r     <= vb_r;
            ra_r    <= rate_first(cmd_r.accel, cmd_r.jerk);
            rd_r    <= rate_first(cmd_r.decel, cmd_r.jerk);
          end
        end
        ST_RUN:
        begin
          if (step_c && rem_r == 34'h0_0000_0001)
          begin
            state_r <= ST_IDLE;
            v_r     <= 21'h00_0000;
          end
          else if (phase_r != PH_DEC && rem_mil <= sd_r)
          begin
            phase_r <= PH_DEC;
          end
          else if (ms_tick_r && phase_r == PH_ACC)
          begin
            v_r  <= add_cap(v_r, ra_r, va_r);
            ra_r <= rate_next(ra_r, cmd_r.accel, cmd_r.jerk);
            if (add_cap(v_r, ra_r, va_r) == va_r)
              phase_r <= PH_CRU;
          end
          else if (ms_tick_r && phase_r == PH_DEC)
          begin
            v_r  <= (v_r > vb_r + rd_r) ? v_r - rd_r : vb_r;
            rd_r <= rate_next(rd_r, cmd_r.decel, cmd_r.jerk);
          end
          if (step_c)
            rem_r <= rem_r - 34'h0_0000_0001;
        end
        ST_HOME:
          if (home_hit)
          begin
            state_r <= ST_IDLE;
            v_r     <= 21'h00_0000;
          end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // Error flag: the set at the end of a calculation wins over the clear.
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      err_r <= 1'b0;
    else if ((state_r == ST_CALC && !a_ok && !d_ok && err_pend_r) || (wr_en && PADDR == `SMPG_ADDR_CMD && state_r != ST_IDLE))
      err_r <= 1'b1;
    else if (cmd_go)
      err_r <= 1'b0;
  end

  // Motor position counter and home reference.
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      pos_r   <= 32'sh0000_0000;
      valid_r <= 1'b0;
    end
    else if (cmd_go && PWDATA[2:0] == `SMPG_OP_PRESET)
    begin
      if (!cfg_fmt_r && cmd_r.target > `SMPG_MW_MAX)
        pos_r <= `SMPG_MW_MAX;
      else if (!cfg_fmt_r && cmd_r.target < `SMPG_MW_MIN)
        pos_r <= `SMPG_MW_MIN;
      else
        pos_r <= cmd_r.target;
      valid_r <= 1'b1;
    end
    else if (home_hit)
    begin
      pos_r   <= 32'sh0000_0000;
      valid_r <= 1'b1;
    end
    else if (!cfg_fmt_r && pos_r > `SMPG_MW_MAX)
      pos_r <= `SMPG_MW_MAX;
    else if (!cfg_fmt_r && pos_r < `SMPG_MW_MIN)
      pos_r <= `SMPG_MW_MIN;
    else if (step_c && cw_r)
    begin
      if (cfg_fmt_r || pos_r != `SMPG_MW_MAX)
        pos_r <= pos_r + 32'sh0000_0001;
    end
    else if (step_c)
    begin
      if (cfg_fmt_r || pos_r != `SMPG_MW_MIN)
        pos_r <= pos_r - 32'sh0000_0001;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N || home_hit)
      enc_r <= 32'sh0000_0000;
    else if (ENC_UP && !ENC_DN)
      enc_r <= enc_r + 32'sh0000_0001;
    else if (ENC_DN && !ENC_UP)
      enc_r <= enc_r - 32'sh0000_0001;
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      STEP_PULSE <= 1'b0;
      DIR_CW     <= 1'b0;
      MOVING     <= 1'b0;
    end
    else
    begin
      STEP_PULSE <= step_c;
      DIR_CW     <= cw_r;
      MOVING     <= acc_phase;
    end
  end

  base_range_a: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    base_r >= `SMPG_BASE_MIN && base_r <= `SMPG_BASE_MAX)
    else $error("Base speed left its legal range.");

  calc_first_a: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    state_r == ST_IDLE |=> state_r != ST_RUN)
    else $error("Motion started without a profile calculation.");

  abs_home_a: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (state_r == ST_RUN && op_r == `SMPG_OP_ABS) |-> valid_r)
    else $error("Absolute move ran without a home reference.");

  step_count_a: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (step_c && cw_r && state_r == ST_RUN && pos_r < `SMPG_MW_MAX && pos_r >= `SMPG_MW_MIN)
      |=> pos_r == $past(pos_r) + 32'sh0000_0001 && STEP_PULSE)
    else $error("Clockwise step did not raise the position by one.");

  mw_limit_a: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (!cfg_fmt_r ##1 !cfg_fmt_r) |-> pos_r <= `SMPG_MW_MAX && pos_r >= `SMPG_MW_MIN)
    else $error("Position left the multi-word range.");

  home_clear_a: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    home_hit |=> pos_r == 32'sh0 && enc_r == 32'sh0 && valid_r && state_r == ST_IDLE)
    else $error("Home did not clear both counters.");

  speed_band_a: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (state_r == ST_RUN) |-> v_r >= vb_r && v_r <= va_r)
    else $error("Run speed outside base to peak band.");

  stop_at_end_a: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (state_r == ST_RUN && step_c && rem_r == 34'h1) |=> state_r == ST_IDLE ##1 !MOVING)
    else $error("Move did not stop at the destination.");

endmodule // smpg_top

// ==== inc/smpg_cfg.svh ====
/*
  Constants of the stepper move profile generator: register offsets, field
  positions, reset values, opcodes and timing counts.
  Assumes a 100 MHz clock and a 32-bit APB register bus with byte addresses.
*/
`ifndef SMPG_CFG_SVH
`define SMPG_CFG_SVH

`define SMPG_ADDR_CMD     8'h00
`define SMPG_ADDR_TARGET  8'h04
`define SMPG_ADDR_SPEED   8'h08
`define SMPG_ADDR_ACCEL   8'h0C
`define SMPG_ADDR_DECEL   8'h10
`define SMPG_ADDR_JERK    8'h14
`define SMPG_ADDR_BASE    8'h18
`define SMPG_ADDR_CFG     8'h1C
`define SMPG_ADDR_STATUS  8'h20
`define SMPG_ADDR_POS     8'h24
`define SMPG_ADDR_ENC     8'h28
`define SMPG_ADDR_VNOW    8'h2C

`define SMPG_OP_REL       3'h1
`define SMPG_OP_ABS       3'h2
`define SMPG_OP_PRESET    3'h3
`define SMPG_OP_HOME_CW   3'h4
`define SMPG_OP_HOME_CCW  3'h5

`define SMPG_CFG_FMT_BIT  0
`define SMPG_BASE_RST     21'h0003E8
`define SMPG_BASE_MIN     21'h000001
`define SMPG_BASE_MAX     21'h1E847F
`define SMPG_REL_MAX      32'sh007F_FFFF
`define SMPG_REL_MIN      32'shFF80_0001
`define SMPG_MW_MAX       32'sh01F3_FFFF
`define SMPG_MW_MIN       32'shFE0C_0000
`define SMPG_ACC_UNIT     48'h0000_0000_03E8

`define SMPG_CLK_PERIOD_NS 32'h0000_000A
`define SMPG_MS_NS         32'h000F_4240
`define SMPG_MS_CYCLES     (`SMPG_MS_NS / `SMPG_CLK_PERIOD_NS)
`define SMPG_STEP_WRAP     28'h5F5_E100

`endif

// ==== inc/smpg_pkg.sv ====
/*
  Types of the stepper move profile generator: states, profile phases and
  the packed carriers for a move command and the status word.
  Assumes nothing of its surroundings.
*/
package smpg_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CALC = 3'b001,
    ST_RUN  = 3'b010,
    ST_HOME = 3'b011
  } smpg_state_e;

  typedef enum logic [1:0] {
    PH_ACC = 2'b00,
    PH_CRU = 2'b01,
    PH_DEC = 2'b10
  } smpg_phase_e;

  typedef struct packed {
    logic signed [31:0] target;
    logic        [20:0] speed;
    logic        [20:0] accel;
    logic        [20:0] decel;
    logic        [12:0] jerk;
  } smpg_cmd_s;

  typedef struct packed {
    smpg_phase_e phase;
    logic        tri_prof;
    logic        cw;
    logic        valid;
    logic        err;
    logic        busy;
  } smpg_stat_s;

endpackage

// ==== testbench/smpg_host.sv ====
/*
  APB host model that issues single register transfers to the profile generator.
  Assumes tb_top owns the mismatch counter and the closing report task.
*/
`timescale 1ns/1ps

module smpg_host (
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // The request is held until the edge that samples pready high; released address and data lines show inverted values.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
    if (pready !== 1'b1)
    begin
      tb_top.errors++;
      tb_top.print_verdict();
    end
  endtask
endmodule // smpg_host

// ==== testbench/tb_top.sv ====
/*
  Self-checking bench of the move profile generator, one task per scenario.
  Assumes the APB host model and a shortened millisecond tick.
*/
`timescale 1ns/1ps
`include "smpg_cfg.svh"

module tb_top;
  localparam logic [7:0] A_CMD = `SMPG_ADDR_CMD;
  localparam logic [7:0] A_TGT = `SMPG_ADDR_TARGET;
  localparam logic [7:0] A_STS = `SMPG_ADDR_STATUS;
  localparam logic [7:0] A_POS = `SMPG_ADDR_POS;
  localparam logic [7:0] A_BAS = `SMPG_ADDR_BASE;
  localparam logic [7:0] A_CFG = `SMPG_ADDR_CFG;
  localparam logic [7:0] A_ENC = `SMPG_ADDR_ENC;
  logic        CLOCK   = 1'b0;
  logic        RST_N   = 1'b0;
  logic        HOME_IN = 1'b0;
  logic        ENC_UP  = 1'b0;
  logic        ENC_DN  = 1'b0;
  logic        PSEL, PENABLE, PWRITE, PREADY, PSLVERR, STEP_PULSE, DIR_CW, MOVING;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, q;
  logic        e, t;
  int          errors   = 0;
  int          compares = 0;
  int          ncw      = 0;
  int          nccw     = 0;

  always #5 CLOCK = ~CLOCK;

  smpg_top #(.MS_TICK_CYCLES(20)) dut_u (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .HOME_IN(HOME_IN), .ENC_UP(ENC_UP), .ENC_DN(ENC_DN), .STEP_PULSE(STEP_PULSE), .DIR_CW(DIR_CW),
    .MOVING(MOVING));

  smpg_host host_u (.clk(CLOCK), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE), .paddr(PADDR),
    .pwdata(PWDATA), .prdata(PRDATA), .pready(PREADY), .pslverr(PSLVERR));

  always @(posedge CLOCK)
  begin
    if (STEP_PULSE === 1'b1 && DIR_CW === 1'b1)
      ncw++;
    else if (STEP_PULSE === 1'b1)
      nccw++;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, q, e);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
    host_u.xfer(1'b0, a, 32'h0, q, e);
    chk(nm, x, q);
  endtask

  // Polls status until idle and records whether a peak below cruise was flagged meanwhile.
  task automatic wait_idle(output logic tr);
    int n;
    n  = 0;
    tr = 1'b0;
    do
    begin
      host_u.xfer(1'b0, A_STS, 32'h0, q, e);
      tr |= q[0] & q[4];
      n++;
    end
    while (q[0] !== 1'b0 && n < 3000);
    if (n >= 3000)
    begin
      errors++;
      print_verdict();
    end
  endtask

  task automatic mv(input logic [2:0] op, input logic [31:0] tgt, input int st, input logic cw,
                    input logic er, input logic tr);
    int c0;
    int a0;
    c0 = ncw;
    a0 = nccw;
    wr(A_TGT, tgt);
    wr(A_CMD, {29'h0, op});
    wait_idle(t);
    chk("cw steps", cw ? st : 0, 32'(ncw - c0));
    chk("ccw steps", cw ? 0 : st, 32'(nccw - a0));
    rdc("status err", A_STS, {q[31:2], er, q[0]});
    chk("triangular", {31'h0, tr}, {31'h0, t});
  endtask

  task automatic t_reset();
    rdc("base reset", A_BAS, 32'h0000_03E8);
    rdc("cfg reset", A_CFG, 32'h0);
    rdc("status reset", A_STS, 32'h0);
    rdc("pos reset", A_POS, 32'h0);
    rdc("unmapped data", 8'h30, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, e});
    $display("test reset done");
  endtask

  task automatic t_base();
    wr(A_BAS, 32'h0);
    rdc("base zero", A_BAS, 32'h0000_03E8);
    wr(A_BAS, 32'h001E_8480);
    rdc("base over", A_BAS, 32'h0000_03E8);
    wr(A_BAS, 32'h0000_0001);
    rdc("base min", A_BAS, 32'h0000_0001);
    wr(A_BAS, 32'h001E_847F);
    rdc("base max", A_BAS, 32'h001E_847F);
    wr(`SMPG_ADDR_SPEED, 32'h001E_847F);
    wr(`SMPG_ADDR_ACCEL, 32'h0000_0001);
    wr(`SMPG_ADDR_DECEL, 32'h0000_0001);
    wr(`SMPG_ADDR_JERK, 32'h0);
    $display("test base done");
  endtask

  task automatic t_moves();
    mv(`SMPG_OP_ABS, 32'h5, 0, 1'b1, 1'b1, 1'b0);
    rdc("pos unmoved", A_POS, 32'h0);
    wr(A_TGT, 32'h5);
    wr(A_CMD, {29'h0, `SMPG_OP_PRESET});
    rdc("preset pos", A_POS, 32'h5);
    host_u.xfer(1'b0, A_STS, 32'h0, q, e);
    chk("pos valid", 32'h1, {31'h0, q[2]});
    mv(`SMPG_OP_REL, 32'h3, 3, 1'b1, 1'b0, 1'b0);
    rdc("rel cw pos", A_POS, 32'h8);
    mv(`SMPG_OP_REL, 32'hFFFF_FFFC, 4, 1'b0, 1'b0, 1'b0);
    rdc("rel ccw pos", A_POS, 32'h4);
    mv(`SMPG_OP_REL, 32'h0080_0000, 0, 1'b1, 1'b1, 1'b0);
    mv(`SMPG_OP_REL, 32'hFF7F_FFFF, 0, 1'b1, 1'b1, 1'b0);
    mv(`SMPG_OP_ABS, 32'hFFFF_FFFE, 6, 1'b0, 1'b0, 1'b0);
    rdc("abs ccw pos", A_POS, 32'hFFFF_FFFE);
    mv(`SMPG_OP_ABS, 32'h1, 3, 1'b1, 1'b0, 1'b0);
    mv(`SMPG_OP_ABS, 32'h0080_0000, 0, 1'b1, 1'b1, 1'b0);
    rdc("abs pos", A_POS, 32'h1);
    $display("test moves done");
  endtask

  task automatic t_home();
    int c0;
    ENC_UP <= 1'b1;
    repeat (3) @(posedge CLOCK);
    ENC_UP <= 1'b0;
    ENC_DN <= 1'b1;
    @(posedge CLOCK);
    ENC_UP <= 1'b1;
    @(posedge CLOCK);
    ENC_UP <= 1'b0;
    ENC_DN <= 1'b0;
    rdc("enc count", A_ENC, 32'h2);
    c0 = ncw;
    wr(A_CMD, {29'h0, `SMPG_OP_HOME_CW});
    repeat (300) @(posedge CLOCK);
    chk("moving", 32'h1, {31'h0, MOVING});
    HOME_IN <= 1'b1;
    wait_idle(t);
    HOME_IN <= 1'b0;
    chk("stopped", 32'h0, {31'h0, MOVING});
    chk("home moved cw", 32'h1, {31'h0, ncw > c0});
    rdc("home pos", A_POS, 32'h0);
    rdc("home enc", A_ENC, 32'h0);
    $display("test home done");
  endtask

  task automatic t_jerk();
    logic [31:0] js [4] = '{32'h0, 32'h1, 32'h2, 32'h1388};
    wr(A_BAS, 32'h000F_4240);
    wr(`SMPG_ADDR_ACCEL, 32'h0001_86A0);
    wr(`SMPG_ADDR_DECEL, 32'h0001_86A0);
    foreach (js[i])
    begin
      wr(`SMPG_ADDR_JERK, js[i]);
      mv(`SMPG_OP_REL, 32'h2, 2, 1'b1, 1'b0, 1'b1);
    end
    rdc("jerk pos", A_POS, 32'h8);
    $display("test jerk done");
  endtask

  task automatic t_fmt();
    wr(A_CFG, 32'h1);
    wr(A_TGT, 32'h7FFF_FFFF);
    wr(A_CMD, {29'h0, `SMPG_OP_PRESET});
    rdc("wide max", A_POS, 32'h7FFF_FFFF);
    wr(A_CFG, 32'h0);
    rdc("multi max", A_POS, 32'h01F3_FFFF);
    wr(A_TGT, 32'h8000_0000);
    wr(A_CMD, {29'h0, `SMPG_OP_PRESET});
    rdc("multi min", A_POS, 32'hFE0C_0000);
    wr(A_CFG, 32'h1);
    wr(A_CMD, {29'h0, `SMPG_OP_PRESET});
    rdc("wide min", A_POS, 32'h8000_0000);
    $display("test format done");
  endtask

  initial
  begin
    repeat (100000) @(posedge CLOCK);
    errors++;
    print_verdict();
  end

  initial
  begin
    repeat (20) @(posedge CLOCK);
    RST_N <= 1'b1;
    t_reset();
    t_base();
    t_moves();
    t_home();
    t_jerk();
    t_fmt();
    print_verdict();
  end
endmodule // tb_top
